// ---- rtl/sdi_fmt_pkg.sv ----
// constants and types shared by the sd conditioning, format lock and identifier logic
package sdi_fmt_pkg;

  // ==========================================================================
  // word and counter widths
  localparam int WORD_W = 10;          // one video word
  localparam int GAP_W  = 13;          // word gap counters, wide enough for 3g lines
  localparam int THR_W  = 4;           // lock match / unlock error thresholds
  localparam int PRG_W  = 16;          // settle interval after a scan rate change

  // ==========================================================================
  // sd transmit conditioning
  localparam logic [7:0] SD_NARROW_ALL_ONES = 8'hFF;  // narrow word that forces a ones fill
  localparam logic [1:0] SD_FILL_ZERO       = 2'h0;
  localparam logic [1:0] SD_FILL_ONE        = 2'h3;
  localparam logic [3:0] LDR_MULT           = 4'hA;  // bits per word, 27 MHz times ten
  localparam int         SD_WIDTH_8         = 0;     // sd width configuration codes
  localparam int         SD_WIDTH_10        = 1;
  localparam int         SD_WIDTH_DYN       = 2;

  // ==========================================================================
  // custom format gap offsets
  localparam logic [GAP_W-1:0] E2S_SUB_HD  = 13'h0005;
  localparam logic [GAP_W-1:0] E2S_SUB_3GA = 13'h0005;
  localparam logic [GAP_W-1:0] E2S_SUB_3GB = 13'h0009;
  localparam logic [GAP_W-1:0] S2E_ADD_HD  = 13'h0003;
  localparam logic [GAP_W-1:0] S2E_ADD_3GA = 13'h0003;
  localparam logic [GAP_W-1:0] S2E_ADD_3GB = 13'h0007;
  localparam logic [GAP_W-1:0] GAP_MAX     = 13'h1FFF; // gap counter saturates here

  // ==========================================================================
  // payload identifier ancillary packet
  localparam logic [WORD_W-1:0] ADF_W0    = 10'h000;
  localparam logic [WORD_W-1:0] ADF_W1    = 10'h3FF;
  localparam logic [7:0]        VPID_DID  = 8'h41;
  localparam logic [7:0]        VPID_SDID = 8'h01;
  localparam logic [7:0]        VPID_DC   = 8'h04;
  localparam int                N_LINKS   = 2;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {RATE_SD, RATE_HD, RATE_3G} rate_t;
  typedef enum logic [1:0] {LK_SETTLE, LK_HUNT, LK_LOCKED} lock_st_t;
  typedef enum logic [2:0] {V_ADF, V_DID, V_SDID, V_DC, V_UDW, V_CS} vpid_st_t;

  // all state registers reset to zero: sd rate, settle state, unlocked
  localparam logic RST_ZERO = 1'b0;

endpackage

// ---- rtl/vpid_extract.sv ----
// payload identifier extraction for one received video link
`timescale 1ns/1ps
module vpid_extract
  import sdi_fmt_pkg::*;
(
  input  wire logic              clk,        // system clock
  input  wire logic              rst_n,      // synchronous reset
  input  wire logic              en,         // advance enable
  input  wire logic [WORD_W-1:0] word,       // received word of this link
  input  wire logic              word_vld,   // word qualifier
  output logic [31:0]            vpid_bytes, // four identifier bytes, first in [7:0]
  output logic                   vpid_vld,   // pulse on a good packet
  output logic                   vpid_err    // pulse on checksum mismatch
);

  typedef struct packed {
    vpid_st_t   st;
    logic [1:0] adf;
    logic [1:0] idx;
    logic [8:0] sum;
    logic [31:0] bytes;
    logic [31:0] out;
    logic        vld;
    logic        err;
  } vst_t;

  vst_t r_reg;
  vst_t r_next;

  // ==========================================================================
  // packet parser: flag, ids, count, four user words, checksum
  always_comb begin
    r_next = r_reg;
    r_next.vld = 1'b0;
    r_next.err = 1'b0;
    if (en && word_vld) begin
      r_next.sum = r_reg.sum + word[8:0];
      case (r_reg.st)
        V_ADF: begin
          r_next.sum = 9'h000;
          if (r_reg.adf == 2'h2 && word == ADF_W1) begin
            r_next.st = V_DID;
            r_next.adf = 2'h0;
          end else if (r_reg.adf == 2'h1 && word == ADF_W1) begin
            r_next.adf = 2'h2;
          end else begin
            r_next.adf = (word == ADF_W0) ? 2'h1 : 2'h0;
          end
        end
        V_DID:  r_next.st = (word[7:0] == VPID_DID) ? V_SDID : V_ADF;
        V_SDID: r_next.st = (word[7:0] == VPID_SDID) ? V_DC : V_ADF;
        V_DC: begin
          r_next.st = (word[7:0] == VPID_DC) ? V_UDW : V_ADF;
          r_next.idx = 2'h0;
        end
        V_UDW: begin
          r_next.bytes = {word[7:0], r_reg.bytes[31:8]};
          r_next.idx = r_reg.idx + 2'h1;
          if (r_reg.idx == 2'h3) begin
            r_next.st = V_CS;
          end
        end
        V_CS: begin
          // a bad checksum keeps the previous identifier on the output
          r_next.st = V_ADF;
          if (word[8:0] == r_reg.sum) begin
            r_next.out = r_reg.bytes;
            r_next.vld = 1'b1;
          end else begin
            r_next.err = 1'b1;
          end
        end
        default: r_next.st = V_ADF;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign vpid_bytes = r_reg.out;
  assign vpid_vld   = r_reg.vld;
  assign vpid_err   = r_reg.err;

endmodule // vpid_extract

// ---- rtl/sdi_format_lock_and_sd_input.sv ----
// sd transmit conditioning, sd receive output, custom format detection and lock control
`timescale 1ns/1ps
module sdi_format_lock_and_sd_input
  import sdi_fmt_pkg::*;
#(
  parameter bit USE_CE       = 1'b0,  // clock enable option
  parameter bit LDR_EN       = 1'b1,  // low rate sd path included
  parameter bit LDR_INT_MULT = 1'b1,  // internal clock multiplier for low rate path
  parameter bit SD_TX_10B    = 1'b1,  // 10-bit sd transmit mode
  parameter bit SEP_SD_IN    = 1'b0,  // dedicated sd data port
  parameter int SD_WIDTH     = SD_WIDTH_DYN, // 8, 10 or dynamic width
  parameter bit SD_RX_10B    = 1'b1,  // 10-bit sd receive mode
  parameter bit CUSTOM_HD    = 1'b1,  // custom hd format detection
  parameter bit CUSTOM_3G    = 1'b1   // custom 3g format detection
) (
  input  wire logic              clk,                    // 250 MHz core clock
  input  wire logic              rst_n,                  // synchronous reset
  input  wire logic              ce,                     // clock enable
  input  wire logic [19:0]       shared_parallel_input,  // common transmit bus
  input  wire logic [WORD_W-1:0] sd_dedicated_in,        // separate sd data port
  input  wire logic              sd_word_en,             // sd word strobe, 27 MHz rate
  input  wire logic              sd_narrow_width_select, // 1: 8-bit sd data
  input  wire logic              ldr_ext_tick,           // external 270 MHz bit tick
  output logic [WORD_W-1:0]      sd_tx_word,             // conditioned sd word
  output logic                   sd_tx_word_vld,         // pulse with new word
  output logic                   ldr_serial_bit,         // low rate serial data
  input  wire logic [19:0]       rx_word,                // received words, link 0 low
  input  wire logic              rx_word_vld,            // received word qualifier
  input  wire logic              rx_sav,                 // start of active trs seen
  input  wire logic              rx_eav,                 // end of active trs seen
  input  wire logic              rx_trs_err,             // trs protection error
  input  wire logic              cfg_range_mode,         // 1: compare with ranges
  input  wire logic              cfg_level_b,            // 3g uses level b offsets
  input  wire logic [GAP_W-1:0]  cfg_words_total,        // words per total line
  input  wire logic [GAP_W-1:0]  cfg_words_active,       // words per active line
  input  wire logic [GAP_W-1:0]  cfg_e2s_min,            // end_to_start_gap minimum
  input  wire logic [GAP_W-1:0]  cfg_e2s_max,            // end_to_start_gap maximum
  input  wire logic [GAP_W-1:0]  cfg_s2e_min,            // start_to_end_gap minimum
  input  wire logic [GAP_W-1:0]  cfg_s2e_max,            // start_to_end_gap maximum
  input  wire logic [PRG_W-1:0]  cfg_prog_sd,            // settle cycles for sd
  input  wire logic [PRG_W-1:0]  cfg_prog_hd,            // settle cycles for hd
  input  wire logic [PRG_W-1:0]  cfg_prog_3g,            // settle cycles for 3g
  input  wire logic [THR_W-1:0]  cfg_lock_match,         // matches needed for lock
  input  wire logic [THR_W-1:0]  cfg_unlock_err,         // errors that drop lock or scan to the next rate
  output logic [1:0]             rx_rate,                // current scan rate
  output logic                   rx_rate_change,         // pulse: reprogram transceiver
  output logic                   rx_locked,              // locked to incoming video
  output logic [WORD_W-1:0]      rx_sd_data,             // received sd word
  output logic                   rx_sd_vld,              // pulse with sd word
  output logic [N_LINKS-1:0][31:0] vpid_bytes,           // identifier per link
  output logic [N_LINKS-1:0]     vpid_vld,               // identifier updated
  output logic [N_LINKS-1:0]     vpid_err                // identifier checksum error
);

  typedef struct packed {
    logic [WORD_W-1:0] tx_word;
    logic              tx_vld;
    logic [WORD_W-1:0] ser_sh;
    logic [3:0]        ser_cnt;
    logic              ser_bit;
    rate_t             rate;
    logic              rate_chg;
    lock_st_t          st;
    logic [PRG_W-1:0]  settle;
    logic [THR_W-1:0]  match;
    logic [THR_W-1:0]  errs;
    logic              locked;
    logic [GAP_W-1:0]  gap;
    logic              seen_sav;
    logic              seen_eav;
    logic [WORD_W-1:0] rx_sd;
    logic              rx_sd_vld;
  } st_t;

  st_t r_reg;
  st_t r_next;

  logic              en;
  logic [WORD_W-1:0] sd_src;
  logic              narrow;
  logic [WORD_W-1:0] ld_word;
  logic              ser_tick;
  logic              custom_on;
  logic [GAP_W-1:0]  blank;
  logic [GAP_W-1:0]  e2s_exp;
  logic [GAP_W-1:0]  s2e_exp;
  logic              e2s_ok;
  logic              s2e_ok;
  logic              trs_ev;
  logic              trs_good;
  logic              trs_bad;
  logic [THR_W:0]    match_inc;
  logic [THR_W:0]    errs_inc;
  rate_t             rate_nxt;
  logic [PRG_W-1:0]  prog_nxt;

  // ==========================================================================
  // sd transmit input selection and width handling
  assign en       = USE_CE ? ce : 1'b1;
  assign sd_src   = (SEP_SD_IN && LDR_EN) ? sd_dedicated_in
                                          : shared_parallel_input[WORD_W-1:0];
  // 8-bit width is forced when 10-bit sd transmit is not configured
  assign narrow   = !SD_TX_10B || (SD_WIDTH == SD_WIDTH_8) ||
                    ((SD_WIDTH == SD_WIDTH_DYN) && sd_narrow_width_select);
  assign ld_word  = narrow ? {sd_src[7:0], (sd_src[7:0] == SD_NARROW_ALL_ONES)
                                           ? SD_FILL_ONE : SD_FILL_ZERO}
                           : sd_src;
  // internal multiplier gives one bit every core cycle; else the external tick paces
  assign ser_tick = LDR_INT_MULT ? 1'b1 : ldr_ext_tick;

  // ==========================================================================
  // expected custom gaps from line geometry
  assign blank     = cfg_words_total - cfg_words_active;
  assign custom_on = ((r_reg.rate == RATE_HD) && CUSTOM_HD) ||
                     ((r_reg.rate == RATE_3G) && CUSTOM_3G);
  always_comb begin
    if (r_reg.rate == RATE_3G) begin
      e2s_exp = {blank[GAP_W-2:0], 1'b0} - (cfg_level_b ? E2S_SUB_3GB : E2S_SUB_3GA);
      s2e_exp = {cfg_words_active[GAP_W-2:0], 1'b0} +
                (cfg_level_b ? S2E_ADD_3GB : S2E_ADD_3GA);
    end else begin
      e2s_exp = blank - E2S_SUB_HD;
      s2e_exp = cfg_words_active + S2E_ADD_HD;
    end
  end

  // gaps are words counted since the previous trs word
  assign e2s_ok = cfg_range_mode ? (r_reg.gap >= cfg_e2s_min && r_reg.gap <= cfg_e2s_max)
                                 : (r_reg.gap == e2s_exp);
  assign s2e_ok = cfg_range_mode ? (r_reg.gap >= cfg_s2e_min && r_reg.gap <= cfg_s2e_max)
                                 : (r_reg.gap == s2e_exp);
  assign trs_ev   = (rx_sav && r_reg.seen_eav) || (rx_eav && r_reg.seen_sav);
  assign trs_good = trs_ev && !rx_trs_err &&
                    (!custom_on || (rx_sav ? e2s_ok : s2e_ok));
  assign trs_bad  = rx_trs_err || (trs_ev && !trs_good);
  assign match_inc = {1'b0, r_reg.match} + 5'h01;
  assign errs_inc  = {1'b0, r_reg.errs} + 5'h01;

  // next scan rate and its settle interval
  always_comb begin
    case (r_reg.rate)
      RATE_SD: begin
        rate_nxt = RATE_HD;
        prog_nxt = cfg_prog_hd;
      end
      RATE_HD: begin
        rate_nxt = RATE_3G;
        prog_nxt = cfg_prog_3g;
      end
      default: begin
        rate_nxt = RATE_SD;
        prog_nxt = cfg_prog_sd;
      end
    endcase
  end

  // ==========================================================================
  // next state: transmit path, gap counter and lock machine
  always_comb begin
    r_next = r_reg;
    r_next.tx_vld = 1'b0;
    r_next.rate_chg = 1'b0;
    r_next.rx_sd_vld = 1'b0;
    if (en) begin
      // word load restarts the shifter; a word arriving mid-shift cuts it short
      if (sd_word_en) begin
        r_next.tx_word = ld_word;
        r_next.tx_vld = 1'b1;
        if (LDR_EN) begin
          r_next.ser_sh = ld_word;
          r_next.ser_cnt = LDR_MULT;
        end
      end else if (LDR_EN && ser_tick && r_reg.ser_cnt != 4'h0) begin
        r_next.ser_bit = r_reg.ser_sh[0];
        r_next.ser_sh = {1'b0, r_reg.ser_sh[WORD_W-1:1]};
        r_next.ser_cnt = r_reg.ser_cnt - 4'h1;
      end
      // sd receive words
      if (rx_word_vld && r_reg.rate == RATE_SD) begin
        r_next.rx_sd = SD_RX_10B ? rx_word[WORD_W-1:0]
                                 : {rx_word[WORD_W-1:2], SD_FILL_ZERO};
        r_next.rx_sd_vld = 1'b1;
      end
      // word gap counter, restarted on each trs
      if (rx_sav || rx_eav) begin
        r_next.gap = '0;
        r_next.seen_sav = rx_sav;
        r_next.seen_eav = rx_eav;
      end else if (rx_word_vld && r_reg.gap != GAP_MAX) begin
        r_next.gap = r_reg.gap + 13'h0001;
      end
      case (r_reg.st)
        LK_SETTLE: begin
          // transceiver reprogramming; trs seen now are not trusted
          r_next.seen_sav = 1'b0;
          r_next.seen_eav = 1'b0;
          if (r_reg.settle == '0) begin
            r_next.st = LK_HUNT;
            r_next.match = '0;
            r_next.errs = '0;
          end else begin
            r_next.settle = r_reg.settle - 16'h0001;
          end
        end
        LK_HUNT: begin
          if (trs_good) begin
            r_next.match = match_inc[THR_W-1:0];
            if (match_inc >= {1'b0, cfg_lock_match}) begin
              r_next.st = LK_LOCKED;
              r_next.locked = 1'b1;
              r_next.errs = '0;
            end
          end else if (trs_bad) begin
            r_next.errs = errs_inc[THR_W-1:0];
            if (errs_inc >= {1'b0, cfg_unlock_err}) begin
              r_next.st = LK_SETTLE;
              r_next.rate = rate_nxt;
              r_next.rate_chg = 1'b1;
              r_next.settle = prog_nxt;
              r_next.match = '0;
              r_next.errs = '0;
            end
          end
        end
        LK_LOCKED: begin
          // only consecutive errors count against lock
          if (trs_good) begin
            r_next.errs = '0;
          end else if (trs_bad) begin
            r_next.errs = errs_inc[THR_W-1:0];
            if (errs_inc >= {1'b0, cfg_unlock_err}) begin
              r_next.st = LK_HUNT;
              r_next.locked = 1'b0;
              r_next.match = '0;
              r_next.errs = '0;
            end
          end
        end
        default: r_next.st = LK_SETTLE;
      endcase
    end
  end

  // state register, everything cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // identifier extraction, one parser per link
  genvar gl;
  generate
    for (gl = 0; gl < N_LINKS; gl++) begin : g_link
      vpid_extract u_vpid (
        .clk        (clk),
        .rst_n      (rst_n),
        .en         (en),
        .word       (rx_word[gl*WORD_W +: WORD_W]),
        .word_vld   (rx_word_vld),
        .vpid_bytes (vpid_bytes[gl]),
        .vpid_vld   (vpid_vld[gl]),
        .vpid_err   (vpid_err[gl])
      );
    end
  endgenerate

  // outputs straight from the state register
  assign sd_tx_word     = r_reg.tx_word;
  assign sd_tx_word_vld = r_reg.tx_vld;
  assign ldr_serial_bit = r_reg.ser_bit;
  assign rx_rate        = r_reg.rate;
  assign rx_rate_change = r_reg.rate_chg;
  assign rx_locked      = r_reg.locked;
  assign rx_sd_data     = r_reg.rx_sd;
  assign rx_sd_vld      = r_reg.rx_sd_vld;

  // ==========================================================================
  // checks
  property p_narrow_fill;
    @(posedge clk) disable iff (!rst_n)
      (en && sd_word_en && narrow) |=> (sd_tx_word[9:2] == $past(sd_src[7:0])) &&
        (sd_tx_word[1:0] == (($past(sd_src[7:0]) == SD_NARROW_ALL_ONES) ? 2'h3 : 2'h0));
  endproperty
  a_narrow_fill: assert property (p_narrow_fill) else $error("narrow sd fill wrong");

  property p_wide_pass;
    @(posedge clk) disable iff (!rst_n)
      (en && sd_word_en && !narrow) |=> sd_tx_word == $past(sd_src);
  endproperty
  a_wide_pass: assert property (p_wide_pass) else $error("wide sd word altered");

  property p_shared_low;
    @(posedge clk) disable iff (!rst_n)
      (en && sd_word_en && !narrow && !(SEP_SD_IN && LDR_EN))
        |=> sd_tx_word == $past(shared_parallel_input[9:0]);
  endproperty
  a_shared_low: assert property (p_shared_low) else $error("sd not from low bits");

  property p_ser_first;
    @(posedge clk) disable iff (!rst_n)
      (LDR_EN && LDR_INT_MULT && en && sd_word_en) ##1 (en && !sd_word_en)
        |=> ldr_serial_bit == $past(ld_word[0], 2);
  endproperty
  a_ser_first: assert property (p_ser_first) else $error("serial bit order wrong");

  property p_settle;
    @(posedge clk) disable iff (!rst_n)
      (en && r_reg.st == LK_SETTLE && r_reg.settle != '0)
        |=> r_reg.st == LK_SETTLE && r_reg.settle == $past(r_reg.settle) - 16'h0001;
  endproperty
  a_settle: assert property (p_settle) else $error("settle interval cut");

  property p_lock;
    @(posedge clk) disable iff (!rst_n)
      (en && r_reg.st == LK_HUNT && trs_good && match_inc >= {1'b0, cfg_lock_match})
        |=> rx_locked ##1 rx_locked || r_reg.st == LK_HUNT;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not declared");

  property p_scan;
    @(posedge clk) disable iff (!rst_n)
      (en && r_reg.st == LK_HUNT && !trs_good && trs_bad &&
       errs_inc >= {1'b0, cfg_unlock_err})
        |=> rx_rate_change && rx_rate != $past(rx_rate) && !rx_locked;
  endproperty
  a_scan: assert property (p_scan) else $error("no rate scan after errors");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !en |=> r_reg.gap == $past(r_reg.gap) && r_reg.settle == $past(r_reg.settle) &&
              rx_rate == $past(rx_rate) && sd_tx_word == $past(sd_tx_word);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with enable low");

  property p_rx_sd;
    @(posedge clk) disable iff (!rst_n)
      (en && rx_word_vld && r_reg.rate == RATE_SD)
        |=> rx_sd_vld && rx_sd_data[9:2] == $past(rx_word[9:2]);
  endproperty
  a_rx_sd: assert property (p_rx_sd) else $error("sd receive word lost");

endmodule // sdi_format_lock_and_sd_input

// ---- verif/line_src.sv ----
// partner model: receive-side video source making trs pulses and word gaps
`timescale 1ns/1ps
module line_src (
  input  wire logic clk,         // core clock
  output logic      rx_sav,      // start of active pulse
  output logic      rx_eav,      // end of active pulse
  output logic      rx_word_vld  // word qualifier
);
  // ==========================================================================
  // one trs word then n valid words, all moved on falling edges
  initial {rx_sav, rx_eav, rx_word_vld} = 3'h0;
  task automatic trs(input bit sav, input int n);
    @(negedge clk) {rx_sav, rx_eav} = {sav, !sav};
    @(negedge clk) {rx_sav, rx_eav} = 2'h0;
    repeat (n) begin
      rx_word_vld = 1'b1;
      @(negedge clk);
    end
    rx_word_vld = 1'b0; // idle gap words are not counted
  endtask
endmodule // line_src

// ---- verif/tb_top.sv ----
// testbench: sd word conditioning, sd receive data, gap checks and lock control
`timescale 1ns/1ps
module tb_top
  import sdi_fmt_pkg::*;
;
  // ==========================================================================
  // signals named as the ports, joined by name
  logic clk, rst_n, ce, sd_word_en, sd_narrow_width_select, ldr_ext_tick;
  logic rx_trs_err, cfg_range_mode, cfg_level_b, sd_tx_word_vld, ldr_serial_bit;
  logic rx_rate_change, rx_locked, rx_sd_vld, rx_sav, rx_eav, rx_word_vld;
  logic [19:0] shared_parallel_input, rx_word;
  logic [WORD_W-1:0] sd_dedicated_in, sd_tx_word, rx_sd_data;
  logic [GAP_W-1:0] cfg_words_total, cfg_words_active, cfg_e2s_min, cfg_e2s_max;
  logic [GAP_W-1:0] cfg_s2e_min, cfg_s2e_max;
  logic [PRG_W-1:0] cfg_prog_sd, cfg_prog_hd, cfg_prog_3g;
  logic [THR_W-1:0] cfg_lock_match, cfg_unlock_err;
  logic [1:0] rx_rate;
  logic [N_LINKS-1:0][31:0] vpid_bytes;
  logic [N_LINKS-1:0] vpid_vld, vpid_err;
  int num_errors = 0;
  int comparisons = 0;
  localparam logic [9:0] SER_WORD = 10'h2A5;
  // identifier packet: flag, ids, count, four user words, checksum
  localparam logic [9:0] PKT [11] = '{10'h000, 10'h3FF, 10'h3FF, 10'h041, 10'h001, 10'h004,
                                      10'h089, 10'h04A, 10'h010, 10'h023, 10'h14C};
  // clock enable option on so that the hold behaviour is exercised
  sdi_format_lock_and_sd_input #(.USE_CE(1'b1)) sdi_format_lock_and_sd_input_i (.*);
  line_src line_src_i (.clk(clk), .rx_sav(rx_sav), .rx_eav(rx_eav), .rx_word_vld(rx_word_vld));
  always #2 clk = ~clk;
  // ==========================================================================
  // checking, bounded waits and the closing report
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_for(input bit on_rate, input logic [1:0] v);
    int n = 0;
    while ((on_rate ? rx_rate : {1'b0, rx_locked}) !== v) begin
      @(negedge clk);
      n++;
      if (n > 60) begin
        num_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        close_out();
      end
    end
    comparisons++;
    $display("test step done at %0t", $time);
  endtask
  // upper shared bits are set to show they never leak into the sd word
  task automatic sd_put(input logic nar, input logic [9:0] d, input logic [9:0] exp);
    @(negedge clk) {shared_parallel_input, sd_narrow_width_select, sd_word_en} = {10'h3FF, d, nar, 1'b1};
    @(negedge clk) sd_word_en = 1'b0;
    chk({3'h0, sd_tx_word}, {3'h0, exp}, "sd word");
    chk({12'h000, sd_tx_word_vld}, 13'h0001, "sd word strobe");
  endtask
  task automatic err_pulse;
    @(negedge clk) rx_trs_err = 1'b1;
    @(negedge clk) rx_trs_err = 1'b0;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {clk, rst_n, sd_word_en, sd_narrow_width_select, ldr_ext_tick, rx_trs_err} = 6'h00;
    {ce, cfg_range_mode, cfg_level_b, shared_parallel_input, sd_dedicated_in} = {3'h4, 30'h0};
    {rx_word, cfg_words_total, cfg_words_active} = {10'h155, 10'h2CB, 13'h0014, 13'h000A};
    {cfg_e2s_min, cfg_e2s_max, cfg_s2e_min, cfg_s2e_max} = {13'h0006, 13'h0006, 13'h000C, 13'h000E};
    {cfg_prog_sd, cfg_prog_hd, cfg_prog_3g} = {16'h0008, 16'h0008, 16'h0008};
    {cfg_lock_match, cfg_unlock_err} = 8'h22;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({11'h0, rx_rate}, 13'h0000, "reset rate");
    sd_put(1'b1, 10'h0FF, 10'h3FF);
    sd_put(1'b1, 10'h012, 10'h048);
    sd_put(1'b1, 10'h0FE, 10'h3F8);
    sd_put(1'b0, SER_WORD, SER_WORD);
    // serial bits leave lsb first, one per core cycle after the load
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      chk({12'h000, ldr_serial_bit}, {12'h000, SER_WORD[k]}, "serial bit");
    end
    // a strobe with enable low must be ignored and the word kept
    @(negedge clk) {ce, sd_word_en, shared_parallel_input} = {2'h1, 20'h0_0000};
    @(negedge clk) {ce, sd_word_en} = 2'h2;
    chk({3'h0, sd_tx_word}, {3'h0, SER_WORD}, "word held with enable low");
    chk({12'h000, sd_tx_word_vld}, 13'h0000, "strobe with enable low");
    repeat (12) @(negedge clk);
    line_src_i.trs(0, 4);
    line_src_i.trs(1, 4);
    chk({3'h0, rx_sd_data}, 13'h02CB, "sd receive word");
    chk({12'h0, rx_sd_vld}, 13'h0001, "sd receive strobe");
    chk({12'h0, rx_locked}, 13'h0000, "lock after one match");
    line_src_i.trs(0, 0);
    wait_for(0, 2'h1);
    err_pulse();
    err_pulse();
    wait_for(0, 2'h0);
    chk({11'h0, rx_rate}, 13'h0000, "rate kept on unlock");
    err_pulse();
    err_pulse();
    wait_for(1, 2'h1);
    chk({12'h0, rx_rate_change}, 13'h0001, "reprogram pulse");
    repeat (12) @(negedge clk);
    line_src_i.trs(1, 13);
    line_src_i.trs(0, 5);
    line_src_i.trs(1, 12);
    wait_for(0, 2'h1);
    cfg_range_mode = 1'b1;
    line_src_i.trs(0, 6);
    line_src_i.trs(1, 7);
    chk({12'h0, rx_locked}, 13'h0001, "range bounds accepted");
    line_src_i.trs(0, 15);
    line_src_i.trs(1, 0);
    wait_for(0, 2'h0);
    // 3g level b in value mode, reached by scanning on from hd
    {cfg_range_mode, cfg_level_b} = 2'h1;
    err_pulse();
    err_pulse();
    wait_for(1, 2'h2);
    repeat (12) @(negedge clk);
    line_src_i.trs(1, 27);
    line_src_i.trs(0, 11);
    line_src_i.trs(1, 0);
    wait_for(0, 2'h1);
    // link 1 gets the same packet with a broken checksum
    fork
      line_src_i.trs(0, 11);
      begin
        @(negedge clk);
        for (int i = 0; i < 11; i++) begin
          @(negedge clk) rx_word = {PKT[i] ^ {9'h000, (i == 10)}, PKT[i]};
        end
      end
    join
    chk({11'h0, vpid_vld}, 13'h0001, "identifier valid per link");
    chk({11'h0, vpid_err}, 13'h0002, "identifier error per link");
    comparisons++;
    if (vpid_bytes[0] !== 32'h2310_4A89) begin
      num_errors++;
      $display("unexpected at %0t: identifier bytes", $time);
    end
    $display("test step done at %0t", $time);
    close_out();
  end
endmodule // tb_top
